/* File: rtl/motor_run_stop_speed_select.sv */
`timescale 1ns/100ps
// Contract
// - factory source: panel alone runs and stops
// - external-with-panel: inputs plus panel controls
// - external-only: inputs only, panel ignored
// - run needs input and RUN switch
// - dial sets speed, switch reverses direction
// - external-only: switch actuation shows indicator
// - external-only: dial in monitor shows indicator
// - indicator steady at RUN, else two seconds
// - exactly one run input starts motor
// - run input released: decelerate to stop
// - both run inputs: instantaneous stop
// - select lines pick entry zero to three
// - run with entry speed, accel, decel
// - select change moves speed without stopping
// - transition uses new entry's ramp times
// - direction switch swaps input to rotation map
// - switch change: decelerate, restart reversed
// - external-only: mapping fixed to forward side
module motor_run_stop_speed_select #(
    parameter int unsigned IND_CYCLES = motor_sel_pkg::IND_CYCLES,
    parameter int unsigned DEB_CYCLES = motor_sel_pkg::DEB_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [motor_sel_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // panel and external inputs
    input wire motor_sel_pkg::panel_t panel,
    input wire motor_sel_pkg::ext_t ext_in,
    // drive command and indicator
    output motor_sel_pkg::drive_t drive,
    output logic panel_disabled
);
    localparam int SW = motor_sel_pkg::SPD_W;

    if (DEB_CYCLES < 1 || DEB_CYCLES > 65535)
        $error("DEB_CYCLES must be 1..65535");
    if (IND_CYCLES < 1)
        $error("IND_CYCLES must be at least 1");

    typedef struct packed {
        motor_sel_pkg::ext_t s1;
        motor_sel_pkg::ext_t s2;
        motor_sel_pkg::ext_t deb;
        logic [15:0] deb_cnt;
        logic [1:0] src;
        logic [1:0] disp;
        logic [3:0][SW-1:0] spd;
        logic [3:0][SW-1:0] acc;
        logic [3:0][SW-1:0] dec;
        logic [SW-1:0] speed;
        logic [SW-1:0] rate_cnt;
        logic cw;
        logic instant;
        logic dir_last;
        logic [31:0] ind_cnt;
        logic ind;
        logic [31:0] rdata;
    } state_t;

    state_t st;
    state_t next_st;
    logic ext_one;
    logic ext_both;
    logic run_req;
    logic want_cw;
    logic [1:0] entry;
    logic [SW-1:0] target;
    logic [SW-1:0] rate;
    logic hit;
    logic [1:0] idx;
    logic [31:0] rd;

    // address decode shared by setup and access phases
    always_comb
    begin
        idx = paddr[3:2];
        hit = (paddr == motor_sel_pkg::CTRL_OFS)
            || (paddr == motor_sel_pkg::STAT_OFS)
            || (paddr[11:4] == motor_sel_pkg::SPEED_BASE[11:4])
            || (paddr[11:4] == motor_sel_pkg::ACC_BASE[11:4])
            || (paddr[11:4] == motor_sel_pkg::DEC_BASE[11:4]);
        hit = hit && (paddr[1:0] == 2'h0);
        rd = 32'h0000_0000;
        if (paddr == motor_sel_pkg::CTRL_OFS)
        begin
            rd[motor_sel_pkg::CTRL_SRC_LSB +: 2] = st.src;
            rd[motor_sel_pkg::CTRL_DISP_LSB +: 2] = st.disp;
        end
        else if (paddr == motor_sel_pkg::STAT_OFS)
        begin
            rd[motor_sel_pkg::STAT_RUN_BIT] = st.speed != '0;
            rd[motor_sel_pkg::STAT_CW_BIT] = st.cw;
            rd[motor_sel_pkg::STAT_ENTRY_LSB +: 2] = entry;
            rd[motor_sel_pkg::STAT_IND_BIT] = st.ind;
            rd[motor_sel_pkg::STAT_SPEED_LSB +: SW] = st.speed;
        end
        else if (paddr[11:4] == motor_sel_pkg::SPEED_BASE[11:4])
            rd[SW-1:0] = st.spd[idx];
        else if (paddr[11:4] == motor_sel_pkg::ACC_BASE[11:4])
            rd[SW-1:0] = st.acc[idx];
        else if (paddr[11:4] == motor_sel_pkg::DEC_BASE[11:4])
            rd[SW-1:0] = st.dec[idx];
    end

    // run decision, direction mapping and target speed
    always_comb
    begin
        ext_one = st.deb.forward_run_input ^ st.deb.bwd;
        ext_both = st.deb.forward_run_input & st.deb.bwd;
        entry = {st.deb.sel_high, st.deb.sel_low};
        run_req = 1'b0;
        want_cw = st.cw;
        unique case (st.src)
            motor_sel_pkg::SRC_PANEL:
            begin
                entry = 2'h0;
                run_req = panel.run_sw;
                want_cw = !panel.dir_sw;
            end
            motor_sel_pkg::SRC_EXT_PANEL:
            begin
                run_req = panel.run_sw && ext_one;
                want_cw = st.deb.forward_run_input ^ panel.dir_sw;
            end
            motor_sel_pkg::SRC_EXT_ONLY:
            begin
                run_req = ext_one;
                want_cw = st.deb.forward_run_input;
            end
            default:
            begin
                run_req = 1'b0;
                want_cw = st.cw;
            end
        endcase
        // a pending reversal ramps to zero first
        if (run_req && (want_cw == st.cw || st.speed == '0))
            target = st.spd[entry];
        else
            target = '0;
        // ramp time comes from the entry now selected
        if (target > st.speed)
            rate = st.acc[entry];
        else
            rate = st.dec[entry];
    end

    // next state
    always_comb
    begin
        next_st = st;
        // two-flop synchroniser then group debounce
        next_st.s1 = ext_in;
        next_st.s2 = st.s1;
        if (st.s2 == st.deb)
            next_st.deb_cnt = 16'h0000;
        else if (st.deb_cnt >= 16'(DEB_CYCLES - 1))
        begin
            next_st.deb = st.s2;
            next_st.deb_cnt = 16'h0000;
        end
        else
            next_st.deb_cnt = st.deb_cnt + 16'h0001;

        // apb setup captures read data, access applies writes
        if (psel && !penable)
            next_st.rdata = rd;
        if (psel && penable && pwrite && hit)
        begin
            if (paddr == motor_sel_pkg::CTRL_OFS)
            begin
                next_st.src = pwdata[motor_sel_pkg::CTRL_SRC_LSB +: 2];
                next_st.disp = pwdata[motor_sel_pkg::CTRL_DISP_LSB +: 2];
            end
            else if (paddr[11:4] == motor_sel_pkg::SPEED_BASE[11:4])
                next_st.spd[idx] = pwdata[SW-1:0];
            else if (paddr[11:4] == motor_sel_pkg::ACC_BASE[11:4])
                next_st.acc[idx] = pwdata[SW-1:0];
            else if (paddr[11:4] == motor_sel_pkg::DEC_BASE[11:4])
                next_st.dec[idx] = pwdata[SW-1:0];
        end
        // dial stores into entry zero while the panel is enabled
        if (panel.dial_move && st.src != motor_sel_pkg::SRC_EXT_ONLY)
            next_st.spd[0] = panel.dial_speed;

        // speed ramp, or an immediate stop on both inputs
        next_st.instant = 1'b0;
        if (ext_both && st.src != motor_sel_pkg::SRC_PANEL)
        begin
            next_st.speed = '0;
            next_st.rate_cnt = '0;
            next_st.instant = 1'b1;
        end
        else if (st.speed != target)
        begin
            if (st.rate_cnt + 16'h0001 >= rate)
            begin
                next_st.rate_cnt = '0;
                if (target > st.speed)
                    next_st.speed = st.speed + 16'h0001;
                else
                    next_st.speed = st.speed - 16'h0001;
            end
            else
                next_st.rate_cnt = st.rate_cnt + 16'h0001;
        end
        else
            next_st.rate_cnt = '0;
        // direction changes only at standstill
        if (st.speed == '0 && run_req)
            next_st.cw = want_cw;

        // rejection indicator
        next_st.dir_last = panel.dir_sw;
        if (st.src == motor_sel_pkg::SRC_EXT_ONLY
            && ((panel.dir_sw != st.dir_last)
            || (panel.dial_move
            && st.disp != motor_sel_pkg::DISP_OTHER)))
            next_st.ind_cnt = IND_CYCLES;
        else if (st.ind_cnt != 32'h0000_0000)
            next_st.ind_cnt = st.ind_cnt - 32'h0000_0001;
        next_st.ind = (st.src == motor_sel_pkg::SRC_EXT_ONLY && panel.run_sw)
            || next_st.ind_cnt != 32'h0000_0000;
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.src <= motor_sel_pkg::SRC_RESET;
            st.disp <= motor_sel_pkg::DISP_RESET;
            st.spd <= {4{motor_sel_pkg::SPEED_RESET}};
            st.acc <= {4{motor_sel_pkg::RATE_RESET}};
            st.dec <= {4{motor_sel_pkg::RATE_RESET}};
            st.cw <= 1'b1;
        end
        else
            st <= next_st;
    end

    // outputs
    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign drive.speed = st.speed;
    assign drive.cw = st.cw;
    assign drive.running = st.speed != '0;
    assign drive.instant_stop = st.instant;
    assign panel_disabled = st.ind;

    // checks
    sequence both_on;
        st.src != motor_sel_pkg::SRC_PANEL && ext_both;
    endsequence
    sequence speed_zero;
        drive.speed == '0 && drive.instant_stop;
    endsequence

    a_panel_only_run: assert property (@(posedge ref_clk) disable iff (rst)
        st.src == motor_sel_pkg::SRC_PANEL && !panel.run_sw |-> !run_req)
        else $error("panel mode ran without run switch");
    a_standby_no_accel: assert property (@(posedge ref_clk) disable iff (rst)
        st.src == motor_sel_pkg::SRC_EXT_PANEL && !panel.run_sw
        && !psel |=> drive.speed <= $past(drive.speed))
        else $error("speed rose with switch at standstill");
    a_ext_only_run: assert property (@(posedge ref_clk) disable iff (rst)
        st.src == motor_sel_pkg::SRC_EXT_ONLY && ext_one |-> run_req)
        else $error("external-only run input ignored");
    a_ind_at_run: assert property (@(posedge ref_clk) disable iff (rst)
        st.src == motor_sel_pkg::SRC_EXT_ONLY && panel.run_sw && !psel
        |=> panel_disabled)
        else $error("indicator missing with switch at run");
    a_dir_reject_ind: assert property (@(posedge ref_clk) disable iff (rst)
        st.src == motor_sel_pkg::SRC_EXT_ONLY && !psel
        && $changed(panel.dir_sw) |=> ##1 panel_disabled [*8])
        else $error("direction change not flagged");
    a_instant_stop: assert property (@(posedge ref_clk) disable iff (rst)
        both_on |=> speed_zero)
        else $error("both inputs did not stop at once");
    a_entry_select: assert property (@(posedge ref_clk) disable iff (rst)
        st.src != motor_sel_pkg::SRC_PANEL
        |-> entry == {st.deb.sel_high, st.deb.sel_low})
        else $error("wrong operation entry selected");
    a_dir_at_rest: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(drive.cw) |-> $past(drive.speed) == '0)
        else $error("direction changed while turning");
    a_ramp_step: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(drive.instant_stop) && !drive.instant_stop
        |-> drive.speed - $past(drive.speed) <= 16'h0001
        || $past(drive.speed) - drive.speed <= 16'h0001)
        else $error("speed jumped without instant stop");
    a_debounce_src: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(st.deb) |-> st.deb == $past(st.s2))
        else $error("debounced inputs bypassed synchroniser");

    // panel source never honours both external inputs
    a_panel_no_instant: assert property (
        @(posedge ref_clk) disable iff (rst)
        st.src == motor_sel_pkg::SRC_PANEL && !psel |=> !drive.instant_stop)
        else $error("instant stop in panel source");
    // without a run request speed only falls
    a_no_run_no_rise: assert property (
        @(posedge ref_clk) disable iff (rst)
        !run_req && !psel |=> drive.speed <= $past(drive.speed))
        else $error("speed rose without run request");
    // external-only start takes the forward-side mapping
    a_ext_only_map: assert property (
        @(posedge ref_clk) disable iff (rst)
        st.src == motor_sel_pkg::SRC_EXT_ONLY && ext_one
        && st.speed == '0 && !psel |=> drive.cw == $past(st.deb.forward_run_input))
        else $error("external-only direction not fixed");
    // dial stores its speed while the panel is live
    a_dial_store: assert property (
        @(posedge ref_clk) disable iff (rst)
        panel.dial_move && st.src != motor_sel_pkg::SRC_EXT_ONLY
        |=> st.spd[0] == $past(panel.dial_speed))
        else $error("dial speed not stored");
    // dial has no effect when the panel is locked out
    a_dial_ignored: assert property (
        @(posedge ref_clk) disable iff (rst)
        panel.dial_move && st.src == motor_sel_pkg::SRC_EXT_ONLY && !psel
        |=> st.spd[0] == $past(st.spd[0]))
        else $error("dial changed speed in external-only");
    // dial turned while the monitor shows speed, alarm or warning
    sequence dial_in_monitor;
        st.src == motor_sel_pkg::SRC_EXT_ONLY && panel.dial_move
        && st.disp != motor_sel_pkg::DISP_OTHER;
    endsequence
    a_dial_reject_ind: assert property (
        @(posedge ref_clk) disable iff (rst)
        dial_in_monitor |=> panel_disabled)
        else $error("dial actuation not flagged");
    // an instant stop pulse always comes with zero speed
    a_instant_zero: assert property (
        @(posedge ref_clk) disable iff (rst)
        drive.instant_stop |-> drive.speed == '0)
        else $error("instant stop with speed left");
endmodule

/* File: common/motor_sel_pkg.sv */
package motor_sel_pkg;
    // widths
    localparam int SPD_W = 16;
    localparam int ADDR_W = 12;
    localparam int N_ENTRIES = 4;

    // clock and timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_KHZ = 250000;
    localparam int IND_TIME_MS = 2000;
    localparam int IND_CYCLES = IND_TIME_MS * CLK_KHZ;
    localparam int DEB_TIME_NS = 1000;
    localparam int DEB_CYCLES = DEB_TIME_NS / CLK_PERIOD_NS;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] STAT_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] SPEED_BASE = 12'h010;
    localparam logic [ADDR_W-1:0] ACC_BASE = 12'h020;
    localparam logic [ADDR_W-1:0] DEC_BASE = 12'h030;

    // field positions
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_DISP_LSB = 2;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_CW_BIT = 1;
    localparam int STAT_ENTRY_LSB = 2;
    localparam int STAT_IND_BIT = 4;
    localparam int STAT_SPEED_LSB = 16;

    // operation source codes
    localparam logic [1:0] SRC_PANEL = 2'h0;
    localparam logic [1:0] SRC_EXT_PANEL = 2'h1;
    localparam logic [1:0] SRC_EXT_ONLY = 2'h2;

    // monitor display codes; panel dial is rejected in the first three
    localparam logic [1:0] DISP_SPEED = 2'h0;
    localparam logic [1:0] DISP_ALARM = 2'h1;
    localparam logic [1:0] DISP_WARNING = 2'h2;
    localparam logic [1:0] DISP_OTHER = 2'h3;

    // reset values
    localparam logic [1:0] SRC_RESET = SRC_PANEL;
    localparam logic [1:0] DISP_RESET = DISP_SPEED;
    localparam logic [SPD_W-1:0] SPEED_RESET = 16'h0000;
    localparam logic [SPD_W-1:0] RATE_RESET = 16'h0001;

    // front panel controls
    typedef struct packed {
        logic run_sw;
        logic dir_sw;
        logic dial_move;
        logic [SPD_W-1:0] dial_speed;
    } panel_t;

    // external operation inputs
    typedef struct packed {
        logic forward_run_input;
        logic bwd;
        logic sel_low;
        logic sel_high;
    } ext_t;

    // drive command towards the commutation logic
    typedef struct packed {
        logic [SPD_W-1:0] speed;
        logic cw;
        logic running;
        logic instant_stop;
    } drive_t;
endpackage

/* File: dv/plc_model.sv */
`timescale 1ns/100ps
// controller on the external run and select inputs
module plc_model (
    // clock
    input wire logic ref_clk,
    // driven inputs of the block
    output motor_sel_pkg::ext_t ext_in
);
    // nothing asserted until commanded
    initial ext_in = '0;
    // select lines first, run inputs one cycle later
    task automatic run(input logic [1:0] sel, input logic f, input logic b);
        @(posedge ref_clk);
        ext_in.sel_low <= sel[0];
        ext_in.sel_high <= sel[1];
        @(posedge ref_clk);
        ext_in.forward_run_input <= f;
        ext_in.bwd <= b;
    endtask
endmodule

/* File: dv/motor_run_stop_speed_select_tb_top.sv */
`timescale 1ns/100ps
module motor_run_stop_speed_select_tb_top;
    localparam int IND = 20;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, slv;
    logic panel_disabled;
    logic [motor_sel_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    motor_sel_pkg::panel_t panel;
    motor_sel_pkg::ext_t ext_in;
    motor_sel_pkg::drive_t drive;
    int err_total, num_checks, cyc, idle, waited;

    // free-running clock
    initial
    begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end

    // block with short indicator and debounce counts
    motor_run_stop_speed_select #(
        .IND_CYCLES(IND),
        .DEB_CYCLES(2)
    ) motor_run_stop_speed_select_inst (
        .ref_clk(ref_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .panel(panel),
        .ext_in(ext_in),
        .drive(drive),
        .panel_disabled(panel_disabled)
    );
    plc_model plc_model_inst (
        .ref_clk(ref_clk),
        .ext_in(ext_in)
    );

    // hang limit and count of stopped cycles
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (drive.running !== 1'h1)
            idle <= idle + 1;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test();
        end
    end

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    // counts and verdict
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one apb transfer; held until pready at an access edge
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        // pready high ends this wait; the bench hang limit is the only timeout
        do
            @(posedge ref_clk);
        while (pready !== 1'h1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // wait for a commanded speed, cycles kept in waited
    task automatic wait_spd(input logic [15:0] s);
        waited = 0;
        while (drive.speed !== s && waited < 300)
        begin
            @(posedge ref_clk);
            waited++;
        end
        check(drive.speed, s);
    endtask

    // one dial actuation
    task automatic dial(input logic [15:0] v);
        @(posedge ref_clk);
        panel.dial_speed <= v;
        panel.dial_move <= 1'h1;
        @(posedge ref_clk);
        panel.dial_move <= 1'h0;
    endtask

    // factory source: panel runs, external inputs ignored
    task automatic t_panel;
        apb(1'h0, motor_sel_pkg::CTRL_OFS, '0);
        check(rd, 32'h0);
        apb(1'h0, 12'h0fc, '0);
        check(slv, 1'h1);
        dial(16'h0006);
        plc_model_inst.run(2'h0, 1'h1, 1'h0);
        repeat (12) @(posedge ref_clk);
        check(drive.speed, 16'h0);
        plc_model_inst.run(2'h0, 1'h0, 1'h0);
        panel.run_sw <= 1'h1;
        wait_spd(16'h6);
        panel.run_sw <= 1'h0;
        wait_spd(16'h0);
    endtask

    // external source with panel live, four entries
    task automatic t_multi;
        int n, i0;
        apb(1'h1, motor_sel_pkg::CTRL_OFS, 32'h1);
        for (n = 0; n < 4; n++)
            apb(1'h1, motor_sel_pkg::SPEED_BASE + 12'(4 * n), 32'(3 + 2 * n));
        panel.run_sw <= 1'h1;
        plc_model_inst.run(2'h0, 1'h1, 1'h0);
        wait_spd(16'h3);
        i0 = idle;
        for (n = 1; n < 4; n++)
        begin
            plc_model_inst.run(2'(n), 1'h1, 1'h0);
            wait_spd(16'(3 + 2 * n));
        end
        check(idle, i0);
        check(drive.cw, 1'h1);
        panel.run_sw <= 1'h0;
        wait_spd(16'h0);
        panel.run_sw <= 1'h1;
        wait_spd(16'h9);
        apb(1'h0, motor_sel_pkg::STAT_OFS, '0);
        check(rd, 32'h0009_000f);
        plc_model_inst.run(2'h3, 1'h0, 1'h0);
        wait_spd(16'h0);
        plc_model_inst.run(2'h3, 1'h0, 1'h1);
        wait_spd(16'h9);
        check(drive.cw, 1'h0);
        panel.dir_sw <= 1'h1;
        wait_spd(16'h0);
        wait_spd(16'h9);
        check(drive.cw, 1'h1);
        plc_model_inst.run(2'h3, 1'h1, 1'h1);
        n = 0;
        while (drive.instant_stop !== 1'h1 && n < 50)
        begin
            @(posedge ref_clk);
            n++;
        end
        check(drive.instant_stop, 1'h1);
        @(posedge ref_clk);
        check(drive.speed, 16'h0);
        apb(1'h1, motor_sel_pkg::ACC_BASE + 12'h004, 32'h4);
        plc_model_inst.run(2'h0, 1'h1, 1'h0);
        wait_spd(16'h3);
        plc_model_inst.run(2'h1, 1'h1, 1'h0);
        wait_spd(16'h4);
        wait_spd(16'h5);
        check(waited, 4);
        plc_model_inst.run(2'h0, 1'h0, 1'h0);
        wait_spd(16'h0);
    endtask

    // external-only source: panel refused, indicator timing
    task automatic t_extonly;
        int n;
        apb(1'h1, motor_sel_pkg::CTRL_OFS, 32'h2);
        panel.run_sw <= 1'h0;
        plc_model_inst.run(2'h0, 1'h0, 1'h1);
        wait_spd(16'h3);
        check(drive.cw, 1'h0);
        panel.dir_sw <= 1'h0;
        repeat (3) @(posedge ref_clk);
        check(panel_disabled, 1'h1);
        n = 0;
        while (panel_disabled === 1'h1 && n < 100)
        begin
            @(posedge ref_clk);
            n++;
        end
        check(n >= IND - 2 && n <= IND, 1'h1);
        check(drive.cw, 1'h0);
        check(drive.speed, 16'h3);
        dial(16'h7);
        repeat (2) @(posedge ref_clk);
        check(panel_disabled, 1'h1);
        panel.run_sw <= 1'h1;
        repeat (3 * IND) @(posedge ref_clk);
        check(panel_disabled, 1'h1);
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        err_total = 0;
        num_checks = 0;
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = '0;
        pwdata = '0;
        panel = '0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        t_panel();
        t_multi();
        t_extonly();
        stop_test();
    end
endmodule
